// ---- inc/frkr_pkg.sv ----
/*
 * Package of the restore-to-defaults key register: object address,
 * key values, access sizes and the request/answer carriers.
 * Assumes the surrounding slave controller decodes frames into one
 * object-dictionary access per request and clocks this block with it.
 */
package frkr_pkg;

    // Object address of the restore entry
    localparam logic [15:0] FRKR_IDX_RESTORE    = 16'h1011;
    localparam logic [7:0]  FRKR_SUB_COUNT      = 8'h00;
    localparam logic [7:0]  FRKR_SUB_KEY        = 8'h01;

    // Read value of subindex 0: one entry follows
    localparam logic [31:0] FRKR_COUNT_VALUE    = 32'h0000_0001;

    // Accepted keys ("load" and its byte-reversed legacy form)
    localparam logic [31:0] FRKR_KEY_LOAD       = 32'h6461_6F6C;
    localparam logic [31:0] FRKR_KEY_ALT        = 32'h6C6F_6164;
    localparam logic [31:0] FRKR_KEY_RESET      = 32'h0000_0000;

    // Access size in bytes; only a full double word may trigger
    localparam logic [2:0]  FRKR_SIZE_FULL      = 3'h4;

    // Object-dictionary access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [2:0]  size;
        logic [31:0] data;
    } frkr_req_type;

    // Answer to one access, one cycle after it is taken
    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [31:0] data;
    } frkr_rsp_type;

    // Restore commands toward the object dictionary storage
    typedef struct packed {
        logic changeable;
        logic backup;
    } frkr_restore_type;

endpackage

// ---- hw/frkr_key_match.sv ----
/*
 * Key comparator of the restore entry: tells whether a written value
 * is the current key or the legacy key, full width only.
 * Assumes data and size are stable in the cycle they are compared.
 */
`timescale 1ns/1ps

module frkr_key_match
    import frkr_pkg::*;
(
    input  wire logic [31:0] data,
    input  wire logic [2:0]  size,
    input  wire logic        legacy_en,
    output logic             load_hit,
    output logic             alt_hit
);

    // Whole 32-bit compare; a shorter access never matches
    wire logic full_size = (size == FRKR_SIZE_FULL);

    // Current key, and the legacy key only where older behaviour is on
    assign load_hit = full_size && (data == FRKR_KEY_LOAD);
    assign alt_hit  = full_size && legacy_en && (data == FRKR_KEY_ALT);

endmodule // frkr_key_match

// ---- hw/frkr_restore_key.sv ----
/*
 * Restore-to-factory-defaults key entry of a fieldbus slave's object
 * dictionary: subindex 1 of the restore object takes a 32-bit key and
 * a matching key fires restore commands to the dictionary storage.
 * Assumes a slave controller that hands over one decoded access per
 * request, on this clock, and that applies the restore commands.
 * The answer to every access comes one enabled clock later; there is
 * no stall, so the controller may issue one access per cycle.
 * A restore is only a pulse, one enabled clock long, on one or both command lines; the storage
 * that holds the dictionary entries does the actual reloading, and
 * nothing reports back when it is done.
 */
// Contract
// - The restore object offers a writable key entry at subindex 1.
// - Writing key 0x64616F6C returns every changeable entry to its default.
// - A valid key also returns all backup objects to their delivery state.
// - With older behaviour enabled, key 0x6C6F6164 restores the backup objects.
// - Any other full written value is only stored as the key entry and starts no restore.
// - No separate completion acknowledgement is produced for a restore.
`timescale 1ns/1ps

module frkr_restore_key
    import frkr_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             legacy_keys,
    input  wire frkr_req_type     od_req,
    output frkr_rsp_type          od_rsp,
    output frkr_restore_type      restore
);

    logic [31:0]      key_q;
    logic [31:0]      key_d;
    frkr_rsp_type     rsp_q;
    frkr_rsp_type     rsp_d;
    frkr_restore_type restore_q;
    frkr_restore_type restore_d;
    logic             load_hit;
    logic             alt_hit;

    // Address decode of the two subindices of the restore object
    wire logic obj_hit   = od_req.valid && (od_req.index == FRKR_IDX_RESTORE);
    wire logic sub0_hit  = obj_hit && (od_req.subindex == FRKR_SUB_COUNT);
    wire logic sub1_hit  = obj_hit && (od_req.subindex == FRKR_SUB_KEY);
    wire logic full_acc  = (od_req.size == FRKR_SIZE_FULL);

    // Key writes must be whole words; subindex 0 is read only
    wire logic write_hit = sub1_hit && od_req.write && full_acc;
    wire logic read_ok   = (sub0_hit || sub1_hit) && !od_req.write;
    wire logic req_ok    = write_hit || read_ok;

    // Key comparison kept separate so the legacy option stays local
    frkr_key_match u_match (
        .data      (od_req.data),
        .size      (od_req.size),
        .legacy_en (legacy_keys),
        .load_hit  (load_hit),
        .alt_hit   (alt_hit)
    );

    // A restore fires only on a whole-word write that matches a key
    wire logic fire_load = write_hit && load_hit;
    wire logic fire_alt  = write_hit && alt_hit;

    // Stored key is what reads return; any full write is kept as written
    // Wrong keys are stored too, so the master can read back what it sent
    assign key_d = write_hit ? od_req.data : key_q;

    // Read data selection for the two subindices
    wire logic [31:0] read_data = sub0_hit ? FRKR_COUNT_VALUE : key_q;

    // Answer: plain access status only, nothing that reports a restore
    // A write answer carries data 0 whether or not it matched a key
    always_comb
    begin
        rsp_d       = '0;
        rsp_d.valid = od_req.valid;
        rsp_d.ok    = req_ok;
        rsp_d.data  = read_ok ? read_data : FRKR_KEY_RESET;
    end

    // Restore commands: load key hits both stores, legacy key only backup
    // The legacy key never touches changeable entries, only the backups
    always_comb
    begin
        restore_d            = '0;
        restore_d.changeable = fire_load;
        restore_d.backup     = fire_load || fire_alt;
    end

    // Key register; frozen while the clock enable is low
    // Reset comes before ce, so a frozen block still clears on reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
            key_q <= FRKR_KEY_RESET;
        else if (ce)
            key_q <= key_d;
    end

    // Answer and command pulses; a pulse held by a low ce is seen again in every cycle that ce stays low
    // Storage must therefore act on the pulse only while ce is high
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rsp_q     <= '0;
            restore_q <= '0;
        end
        else if (ce)
        begin
            rsp_q     <= rsp_d;
            restore_q <= restore_d;
        end
    end

    // Outputs straight from the flops, so the master never sees decode glitches
    assign od_rsp  = rsp_q;
    assign restore = restore_q;

    // Checks on reset and clock enable; reset is checked without the disable
    a_reset_clears: assert property (@(posedge clk)
        !nrst |=> !od_rsp.valid && !restore.changeable && !restore.backup
            && key_q == FRKR_KEY_RESET)
        else $error("reset left the key entry or its outputs set");

    a_ce_freezes: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> $stable(key_q) && $stable(od_rsp) && $stable(restore))
        else $error("state moved while the clock enable was low");

    // Checks on stored key and readback
    a_key_write_stored: assert property (@(posedge clk) disable iff (!nrst)
        ce && write_hit |=> key_q == $past(od_req.data))
        else $error("key entry did not keep the written value");

    a_key_read_back: assert property (@(posedge clk) disable iff (!nrst)
        ce && sub1_hit && !od_req.write |=> od_rsp.valid && od_rsp.ok
            && od_rsp.data == $past(key_q))
        else $error("key entry read did not return the stored value");

    a_count_read: assert property (@(posedge clk) disable iff (!nrst)
        ce && sub0_hit && !od_req.write |=> od_rsp.valid && od_rsp.ok
            && od_rsp.data == FRKR_COUNT_VALUE)
        else $error("entry count read returned a wrong value");

    // Checks on restore commands and their cause
    a_load_restores_all: assert property (@(posedge clk) disable iff (!nrst)
        ce && write_hit && od_req.data == FRKR_KEY_LOAD
            |=> restore.changeable && restore.backup)
        else $error("load key did not restore changeable entries");

    a_changeable_cause: assert property (@(posedge clk) disable iff (!nrst)
        $rose(restore.changeable) |-> $past(write_hit)
            && $past(od_req.data) == FRKR_KEY_LOAD)
        else $error("changeable restore without the load key");

    a_backup_cause: assert property (@(posedge clk) disable iff (!nrst)
        $rose(restore.backup) |-> $past(write_hit) && ($past(od_req.data) == FRKR_KEY_LOAD
            || ($past(od_req.data) == FRKR_KEY_ALT && $past(legacy_keys))))
        else $error("backup restore without an accepted key");

    a_backup_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
        ce && restore.backup && !fire_load && !fire_alt |=> !restore.backup)
        else $error("backup command stayed high past one cycle");

    a_alt_backup_only: assert property (@(posedge clk) disable iff (!nrst)
        ce && write_hit && legacy_keys && od_req.data == FRKR_KEY_ALT
            |=> restore.backup && !restore.changeable)
        else $error("legacy key did not restore only backup objects");

    a_alt_needs_legacy: assert property (@(posedge clk) disable iff (!nrst)
        ce && write_hit && !legacy_keys && od_req.data == FRKR_KEY_ALT
            |=> !restore.backup && !restore.changeable)
        else $error("legacy key acted while older behaviour was off");

    a_wrong_key_inert: assert property (@(posedge clk) disable iff (!nrst)
        ce && od_req.valid && od_req.data != FRKR_KEY_LOAD
            && !(legacy_keys && od_req.data == FRKR_KEY_ALT)
            |=> !restore.changeable && !restore.backup)
        else $error("restore fired on a value that is not a key");

    a_read_no_pulse: assert property (@(posedge clk) disable iff (!nrst)
        ce && od_req.valid && !od_req.write
            |=> !restore.changeable && !restore.backup)
        else $error("restore fired on a read");

    a_refused_key_kept: assert property (@(posedge clk) disable iff (!nrst)
        ce && od_req.valid && !write_hit |=> key_q == $past(key_q))
        else $error("key entry changed without an accepted write");

    a_refused_not_ok: assert property (@(posedge clk) disable iff (!nrst)
        ce && od_req.valid && !req_ok |=> od_rsp.valid && !od_rsp.ok
            && od_rsp.data == FRKR_KEY_RESET)
        else $error("refused access was answered as accepted");

    // Checks on the answer: access status only, never a restore report
    a_rsp_only_on_req: assert property (@(posedge clk) disable iff (!nrst)
        ce ##1 od_rsp.valid |-> $past(od_req.valid))
        else $error("answer given without a request");

    a_idle_no_rsp: assert property (@(posedge clk) disable iff (!nrst)
        ce && !od_req.valid |=> !od_rsp.valid)
        else $error("answer given in an idle cycle");

    a_write_no_ack: assert property (@(posedge clk) disable iff (!nrst)
        ce && write_hit |=> od_rsp.valid && od_rsp.ok
            && od_rsp.data == FRKR_KEY_RESET)
        else $error("key write answer carried more than a status");

    a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
        ce && restore.changeable && !fire_load |=> !restore.changeable)
        else $error("restore command stayed high past one cycle");

    a_partial_ignored: assert property (@(posedge clk) disable iff (!nrst)
        ce && sub1_hit && od_req.write && od_req.size != FRKR_SIZE_FULL
            |=> !restore.backup && !restore.changeable && !od_rsp.ok
            && key_q == $past(key_q))
        else $error("partial write reached the key entry");

endmodule // frkr_restore_key

// ---- test/frkr_master_model.sv ----
/*
 * Master-side model that issues object accesses to the restore entry.
 * Assumes the bench calls access() just after a rising clock edge
 * and lets one clock edge pass between two calls.
 */
`timescale 1ns/1ps

module frkr_master
    import frkr_pkg::*;
(
    input  wire logic         clk,
    input  wire frkr_rsp_type od_rsp,
    output frkr_req_type      od_req
);
    frkr_rsp_type got;

    // One access per call; released lines show the inverse so stale values never pass
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [2:0] sz, input logic [31:0] d);
        od_req <= '{1'b1, wr, idx, sub, sz, d};
        @(posedge clk);
        #1;
        od_req <= '{1'b0, ~wr, ~idx, ~sub, ~sz, ~d};
        got = od_rsp;
    endtask

    initial od_req = '0;
endmodule // frkr_master

// ---- test/tb_top.sv ----
/*
 * Self-checking bench of the restore key entry.
 * Assumes the master model drives accesses and the answer comes one cycle later.
 */
`timescale 1ns/1ps

module tb_top
    import frkr_pkg::*;
;
    logic             clk;
    logic             nrst;
    logic             ce;
    logic             legacy_keys;
    frkr_req_type     od_req;
    frkr_rsp_type     od_rsp;
    frkr_restore_type restore;
    int               fails;
    int               checked;

    frkr_restore_key u_dut (.clk(clk), .nrst(nrst), .ce(ce), .legacy_keys(legacy_keys),
                            .od_req(od_req), .od_rsp(od_rsp), .restore(restore));
    frkr_master m (.clk(clk), .od_rsp(od_rsp), .od_req(od_req));

    // Clock at 25 MHz
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One access, then answer and restore pulses compared in the answer cycle
    task automatic acc_chk(input logic wr, input logic [7:0] sub, input logic [2:0] sz,
                           input logic [31:0] d, input logic ok, input logic [1:0] rs,
                           input logic [31:0] rd, input logic [15:0] idx = FRKR_IDX_RESTORE);
        m.access(wr, idx, sub, sz, d);
        check({m.got.valid, m.got.ok, restore, m.got.data}, {1'b1, ok, rs, rd});
        // One idle edge between transfers, so the request is never set twice in a step
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset_values();
        acc_chk(0, FRKR_SUB_KEY, FRKR_SIZE_FULL, 0, 1, 0, FRKR_KEY_RESET);
        acc_chk(0, FRKR_SUB_COUNT, FRKR_SIZE_FULL, 0, 1, 0, FRKR_COUNT_VALUE);
    endtask

    // Read-back after the write also shows the pulse did not stay high
    task automatic t_load_key();
        acc_chk(1, FRKR_SUB_KEY, FRKR_SIZE_FULL, FRKR_KEY_LOAD, 1, 2'b11, 0);
        acc_chk(0, FRKR_SUB_KEY, FRKR_SIZE_FULL, 0, 1, 0, FRKR_KEY_LOAD);
    endtask

    task automatic t_legacy_key();
        legacy_keys = 1'b1;
        acc_chk(1, FRKR_SUB_KEY, FRKR_SIZE_FULL, FRKR_KEY_ALT, 1, 2'b01, 0);
        legacy_keys = 1'b0;
        acc_chk(1, FRKR_SUB_KEY, FRKR_SIZE_FULL, FRKR_KEY_ALT, 1, 0, 0);
        acc_chk(0, FRKR_SUB_KEY, FRKR_SIZE_FULL, 0, 1, 0, FRKR_KEY_ALT);
    endtask

    // Near-miss key and misplaced writes must start nothing
    task automatic t_no_effect();
        acc_chk(1, FRKR_SUB_KEY, FRKR_SIZE_FULL, 32'h6461_6F6D, 1, 0, 0);
        acc_chk(1, FRKR_SUB_COUNT, FRKR_SIZE_FULL, FRKR_KEY_LOAD, 0, 0, 0);
        acc_chk(1, FRKR_SUB_KEY, FRKR_SIZE_FULL, FRKR_KEY_LOAD, 0, 0, 0, 16'h1012);
        acc_chk(0, 8'h02, FRKR_SIZE_FULL, 0, 0, 0, 0);
    endtask

    // Every size but a full word is refused; stored key stays the near-miss value
    task automatic t_partial();
        for (int s = 0; s < 8; s++)
            if (s != 4)
                acc_chk(1, FRKR_SUB_KEY, 3'(s), FRKR_KEY_LOAD, 0, 0, 0);
        acc_chk(0, FRKR_SUB_KEY, FRKR_SIZE_FULL, 0, 1, 0, 32'h6461_6F6D);
    endtask

    // Low ce freezes answer and pulses; reset still acts while ce is low
    task automatic t_freeze_reset();
        ce = 1'b0;
        m.access(1, FRKR_IDX_RESTORE, FRKR_SUB_KEY, FRKR_SIZE_FULL, FRKR_KEY_LOAD);
        check({m.got.valid, m.got.ok, restore, m.got.data}, 36'h0);
        nrst = 1'b0;
        @(posedge clk);
        #1;
        nrst = 1'b1;
        ce = 1'b1;
        @(posedge clk);
        #1;
        acc_chk(0, FRKR_SUB_KEY, FRKR_SIZE_FULL, 0, 1, 0, FRKR_KEY_RESET);
    endtask

    initial
    begin
        fails = 0;
        checked = 0;
        nrst = 1'b0;
        ce = 1'b1;
        legacy_keys = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        @(posedge clk);
        #1;
        t_reset_values();
        t_load_key();
        t_legacy_key();
        t_no_effect();
        t_partial();
        t_freeze_reset();
        tally_and_finish();
    end

    // Watchdog far beyond the few dozen cycles the tests need
    initial
    begin
        #(40 * 2000);
        fails++;
        tally_and_finish();
    end
endmodule // tb_top
